/* File: pmsc_pkg.sv */
package pmsc_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_CTRL2   = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ     = 8'h08;
    localparam logic [7:0] ADDR_MASK    = 8'h0c;

    // ********************************************************
    // Control 2 field positions
    // ********************************************************
    localparam int BIT_WARN_FLAG   = 7;
    localparam int BIT_WARN_ACK    = 6;
    localparam int BIT_DET_TRIP    = 5;
    localparam int BIT_WARN_TRIP   = 4;
    localparam int BIT_S2_FLAG     = 3;
    localparam int BIT_S2_ACK      = 2;
    localparam int BIT_PD_EN       = 1;
    localparam int BIT_PD_MODE     = 0;

    // ********************************************************
    // Interrupt status bits
    // ********************************************************
    localparam int IRQ_WARN = 0;
    localparam int IRQ_S2   = 1;
    localparam int IRQ_W    = 2;

    localparam logic [1:0] MASK_RST = 2'h0;

    // Reset causes presented with each reset
    typedef enum logic [2:0] {
        PMSC_CAUSE_POR   = 3'b001,
        PMSC_CAUSE_LVR   = 3'b010,
        PMSC_CAUSE_OTHER = 3'b100
    } pmsc_cause_t;

    typedef struct packed {
        logic det_trip;
        logic warn_trip;
    } pmsc_trip_t;

    typedef struct packed {
        logic pd_en;
        logic pd_mode;
        logic written;
    } pmsc_pd_t;

endpackage

/* File: pmsc_ctrl2.sv */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Warning flag sets below trip, also after reset
// - Warning flag sticky until acknowledged
// - Warning ack clears only if condition gone
// - Detect trip select: 0 low, 1 high
// - Warning trip select picks warning threshold
// - Stop2 flag set on stop2 recovery
// - Stop2 ack write 1 clears flag
// - Power-down enable writable once after reset
// - Mode select writable once; 0 stop1, 1 stop2
module pmsc_ctrl2 (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pmsc_pkg::pmsc_cause_t reset_cause,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  warning_present,
    input  wire logic                  stop2_wake,
    output logic                       detect_trip_select,
    output logic                       warning_trip_select,
    output logic                       power_down_enable,
    output logic                       power_down_mode_select,
    output logic                       irq
);

    // ********************************************************
    // Bus decode
    // ********************************************************
    wire logic setup_phase  = psel & ~penable;
    wire logic access_done  = psel & penable & pready;
    wire logic wr_done      = access_done & pwrite;
    wire logic rd_done      = access_done & ~pwrite;
    wire logic hit_ctrl     = paddr == pmsc_pkg::ADDR_CTRL2;
    wire logic hit_status   = paddr == pmsc_pkg::ADDR_STATUS;
    wire logic hit_irq      = paddr == pmsc_pkg::ADDR_IRQ;
    wire logic hit_mask     = paddr == pmsc_pkg::ADDR_MASK;
    wire logic hit_any      = hit_ctrl | hit_status | hit_irq | hit_mask;
    wire logic wr_ctrl      = wr_done & hit_ctrl;
    wire logic wr_mask      = wr_done & hit_mask;
    wire logic rd_irq       = rd_done & hit_irq;
    wire logic warn_ack     = wr_ctrl & pwdata[pmsc_pkg::BIT_WARN_ACK];
    wire logic s2_ack       = wr_ctrl & pwdata[pmsc_pkg::BIT_S2_ACK];

    // ********************************************************
    // State
    // ********************************************************
    logic                  warn_flag_ff;
    logic                  s2_flag_ff;
    pmsc_pkg::pmsc_trip_t  trip_ff;
    pmsc_pkg::pmsc_pd_t    pd_ff;
    logic                  cause_seen_ff;
    logic [1:0]            irq_stat_ff;
    logic [1:0]            mask_ff;
    logic                  pready_ff;
    logic [31:0]           prdata_ff;
    logic                  pslverr_ff;
    logic                  irq_ff;

    // Set has priority, so an event in the clearing cycle is never lost
    function automatic logic sticky_next(input logic set, input logic cur, input logic clr);
        return set | (cur & ~clr);
    endfunction

    wire logic nxt_warn_flag = sticky_next(warning_present, warn_flag_ff, warn_ack);
    wire logic nxt_s2_flag   = sticky_next(stop2_wake, s2_flag_ff, s2_ack);

    wire logic warn_rise = warning_present & ~warn_flag_ff;
    wire logic s2_rise   = stop2_wake & ~s2_flag_ff;
    // A read clears only the bits it returned; an event during the transfer survives
    wire logic [1:0] irq_rd_bits  = rd_irq ? prdata_ff[1:0] : 2'h0;
    wire logic [1:0] nxt_irq_stat = {s2_rise, warn_rise} | (irq_stat_ff & ~irq_rd_bits);
    wire logic [1:0] nxt_mask     = wr_mask ? pwdata[1:0] : mask_ff;

    // Trip selects are only reinitialised by power-on reset; other resets arrive
    // with presetn too, so the cause is sampled at every edge while presetn is low and at the first edge after release.
    wire logic por_clear = ~cause_seen_ff && reset_cause == pmsc_pkg::PMSC_CAUSE_POR;

    // Only the first write after reset lands; later writes leave both bits alone
    wire logic pd_load = wr_ctrl & ~pd_ff.written;

    // Ack bits and unused bits read as zero
    wire logic [7:0] ctrl_view = {warn_flag_ff, 1'b0, trip_ff.det_trip, trip_ff.warn_trip,
                                  s2_flag_ff, 1'b0, pd_ff.pd_en, pd_ff.pd_mode};
    wire logic [31:0] rd_mux = hit_ctrl   ? {24'h0, ctrl_view} :
                               hit_status ? {30'h0, s2_flag_ff, warn_flag_ff} :
                               hit_irq    ? {30'h0, irq_stat_ff} :
                               hit_mask   ? {30'h0, mask_ff} : 32'h0;

    // ********************************************************
    // Flags and write-once controls
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_flag_ff  <= 1'b0;
            s2_flag_ff    <= 1'b0;
            pd_ff         <= '0;
            cause_seen_ff <= 1'b0;
        end else begin
            warn_flag_ff  <= nxt_warn_flag;
            s2_flag_ff    <= nxt_s2_flag;
            cause_seen_ff <= 1'b1;
            if (pd_load) begin
                pd_ff.pd_en   <= pwdata[pmsc_pkg::BIT_PD_EN];
                pd_ff.pd_mode <= pwdata[pmsc_pkg::BIT_PD_MODE];
                pd_ff.written <= 1'b1;
            end
        end
    end

    // Trip selects have no asynchronous reset: they survive non-POR resets
    always_ff @(posedge pclk) begin
        if (por_clear) begin
            trip_ff <= '0;
        end else if (wr_ctrl) begin
            trip_ff.det_trip  <= pwdata[pmsc_pkg::BIT_DET_TRIP];
            trip_ff.warn_trip <= pwdata[pmsc_pkg::BIT_WARN_TRIP];
        end
    end

    // ********************************************************
    // Interrupts and bus answer
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 2'h0;
            mask_ff     <= pmsc_pkg::MASK_RST;
            irq_ff      <= 1'b0;
            pready_ff   <= 1'b0;
            prdata_ff   <= 32'h0;
            pslverr_ff  <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            mask_ff     <= nxt_mask;
            irq_ff      <= |(nxt_irq_stat & nxt_mask);
            pready_ff   <= setup_phase;
            prdata_ff   <= setup_phase ? rd_mux : 32'h0;
            pslverr_ff  <= setup_phase & ~hit_any;
        end
    end

    assign prdata                 = prdata_ff;
    assign pready                 = pready_ff;
    assign pslverr                = pslverr_ff;
    assign irq                    = irq_ff;
    assign detect_trip_select     = trip_ff.det_trip;
    assign warning_trip_select    = trip_ff.warn_trip;
    assign power_down_enable      = pd_ff.pd_en;
    assign power_down_mode_select = pd_ff.pd_mode;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence warn_seen;
        warning_present;
    endsequence

    chk_warn_sets: assert property (@(posedge pclk) disable iff (!presetn)
        warn_seen |=> warn_flag_ff) else $error("warning flag not set");
    chk_warn_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        warn_flag_ff && !warn_ack |=> warn_flag_ff) else $error("warning flag dropped");
    chk_warn_ack_held: assert property (@(posedge pclk) disable iff (!presetn)
        warn_ack && warning_present |=> warn_flag_ff) else $error("ack cleared live warning");
    chk_warn_ack_clr: assert property (@(posedge pclk) disable iff (!presetn)
        warn_ack && !warning_present |=> !warn_flag_ff) else $error("ack failed to clear");
    chk_trip_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !por_clear |=> detect_trip_select == $past(pwdata[5])
        && warning_trip_select == $past(pwdata[4])) else $error("trip select not stored");
    chk_s2_set: assert property (@(posedge pclk) disable iff (!presetn)
        stop2_wake |=> s2_flag_ff) else $error("stop2 flag not set");
    chk_s2_ack: assert property (@(posedge pclk) disable iff (!presetn)
        s2_ack && !stop2_wake |=> !s2_flag_ff) else $error("stop2 ack ignored");
    chk_pd_once: assert property (@(posedge pclk) disable iff (!presetn)
        pd_ff.written |=> $stable(power_down_enable) && $stable(power_down_mode_select))
        else $error("write-once control changed");
    chk_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && $past(hit_ctrl) |-> prdata[6] == 1'b0 && prdata[2] == 1'b0)
        else $error("ack bit read nonzero");

    // ********************************************************
    // Transfer sequences
    // ********************************************************
    sequence bus_setup;
        psel && !penable;
    endsequence

    sequence bus_access;
        psel && penable;
    endsequence

    sequence ctrl_read_setup;
        psel && !penable && !pwrite && hit_ctrl;
    endsequence

    sequence ctrl_write_done;
        wr_ctrl;
    endsequence

    sequence first_ctrl_write;
        wr_ctrl && !pd_ff.written;
    endsequence

    sequence s2_seen;
        stop2_wake;
    endsequence

    // ********************************************************
    // Bus answer checks
    // ********************************************************
    chk_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        bus_setup |=> pready)
        else $error("no ready after setup");

    chk_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        bus_setup ##1 bus_access |=> !pready)
        else $error("ready held too long");

    chk_ready_origin: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(setup_phase))
        else $error("ready without setup");

    chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0)
        else $error("read data outside answer");

    chk_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");

    chk_err_decode: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> pslverr == !$past(hit_any))
        else $error("error flag wrong for address");

    chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    // ********************************************************
    // Control register checks
    // ********************************************************
    chk_flag_readback: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_read_setup |=> pready && prdata[pmsc_pkg::BIT_WARN_FLAG] == $past(warn_flag_ff)
        && prdata[pmsc_pkg::BIT_S2_FLAG] == $past(s2_flag_ff))
        else $error("flag readback wrong");

    chk_trip_readback: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_read_setup |=> prdata[pmsc_pkg::BIT_DET_TRIP] == $past(detect_trip_select)
        && prdata[pmsc_pkg::BIT_WARN_TRIP] == $past(warning_trip_select))
        else $error("trip readback wrong");

    chk_pd_readback: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_read_setup |=> prdata[pmsc_pkg::BIT_PD_EN] == $past(power_down_enable)
        && prdata[pmsc_pkg::BIT_PD_MODE] == $past(power_down_mode_select))
        else $error("power-down readback wrong");

    chk_pd_first: assert property (@(posedge pclk) disable iff (!presetn)
        first_ctrl_write |=> pd_ff.written && power_down_enable == $past(pwdata[pmsc_pkg::BIT_PD_EN])
        && power_down_mode_select == $past(pwdata[pmsc_pkg::BIT_PD_MODE]))
        else $error("first control write lost");

    chk_pd_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pd_ff.written |-> !power_down_enable && !power_down_mode_select)
        else $error("power-down set without write");

    // ********************************************************
    // Flag checks
    // ********************************************************
    chk_warn_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !warn_flag_ff && !warning_present |=> !warn_flag_ff)
        else $error("warning flag set without cause");

    chk_s2_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        s2_flag_ff && !s2_ack |=> s2_flag_ff)
        else $error("stop2 flag dropped");

    chk_s2_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !s2_flag_ff && !stop2_wake |=> !s2_flag_ff)
        else $error("stop2 flag set without wake");

    chk_s2_ack_wake: assert property (@(posedge pclk) disable iff (!presetn)
        s2_ack && stop2_wake |=> s2_flag_ff)
        else $error("ack beat stop2 wake");

    chk_s2_ack_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write_done ##0 (!pwdata[pmsc_pkg::BIT_S2_ACK] && s2_flag_ff) |=> s2_flag_ff)
        else $error("zero ack cleared stop2 flag");

    chk_s2_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
        s2_seen |=> s2_flag_ff && irq_stat_ff[pmsc_pkg::IRQ_S2] | $past(s2_flag_ff))
        else $error("stop2 wake not recorded");

    // ********************************************************
    // Reset checks
    // ********************************************************
    chk_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
        !cause_seen_ff |-> !pd_ff.written && !power_down_enable && !power_down_mode_select
        && !s2_flag_ff && !warn_flag_ff)
        else $error("reset left state behind");

    chk_por_trip: assert property (@(posedge pclk) disable iff (!presetn)
        por_clear |=> !detect_trip_select && !warning_trip_select)
        else $error("trip selects kept over power-on");

    chk_trip_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !por_clear && !wr_ctrl |=> $stable(detect_trip_select) && $stable(warning_trip_select))
        else $error("trip select changed unasked");

    // ********************************************************
    // Interrupt checks
    // ********************************************************
    chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mask |=> mask_ff == $past(pwdata[1:0]))
        else $error("mask write lost");

    chk_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_mask |=> $stable(mask_ff))
        else $error("mask changed unasked");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(irq_stat_ff & mask_ff))
        else $error("interrupt level wrong");

    chk_irq_warn_evt: assert property (@(posedge pclk) disable iff (!presetn)
        warn_rise |=> irq_stat_ff[pmsc_pkg::IRQ_WARN])
        else $error("warning event not recorded");

    chk_irq_s2_evt: assert property (@(posedge pclk) disable iff (!presetn)
        s2_rise |=> irq_stat_ff[pmsc_pkg::IRQ_S2])
        else $error("stop2 event not recorded");

    chk_irq_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_irq && !warn_rise && !s2_rise |=> (irq_stat_ff & $past(prdata_ff[1:0])) == 2'h0)
        else $error("read did not clear status");

    chk_irq_no_event: assert property (@(posedge pclk) disable iff (!presetn)
        !warn_rise && !s2_rise && !rd_irq |=> $stable(irq_stat_ff))
        else $error("status changed without event");

endmodule

/* File: pmsc_ctrl2_bench.sv */
`timescale 1ns/1ps
module pmsc_ctrl2_bench;
    logic                  pclk            = 1'b0;
    logic                  presetn         = 1'b0;
    pmsc_pkg::pmsc_cause_t reset_cause     = pmsc_pkg::PMSC_CAUSE_POR;
    logic                  psel            = 1'b0;
    logic                  penable         = 1'b0;
    logic                  pwrite          = 1'b0;
    logic [7:0]            paddr           = 8'h00;
    logic [31:0]           pwdata          = 32'h0;
    logic                  warning_present = 1'b0;
    logic                  stop2_wake      = 1'b0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  det_trip;
    logic                  warn_trip;
    logic                  pd_en;
    logic                  pd_mode;
    logic                  irq;
    logic [31:0]           rdat;
    logic                  rerr;
    int                    error_cnt       = 0;
    int                    tests_run       = 0;

    always #25 pclk = ~pclk;

    pmsc_ctrl2 uut (.pclk(pclk), .presetn(presetn), .reset_cause(reset_cause), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .warning_present(warning_present),
        .stop2_wake(stop2_wake), .detect_trip_select(det_trip),
        .warning_trip_select(warn_trip), .power_down_enable(pd_en),
        .power_down_mode_select(pd_mode), .irq(irq));

    // ********************************************************
    // Bus and check tasks
    // ********************************************************
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rst(input pmsc_pkg::pmsc_cause_t c);
        @(posedge pclk);
        presetn     <= 1'b0;
        reset_cause <= c;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        if (pready !== 1'b1) chk("pready", 32'h0, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdat, e);
    endtask

    task automatic outc(input logic [31:0] e);
        repeat (2) @(negedge pclk);
        chk("ctrl_outs", {28'h0, det_trip, warn_trip, pd_en, pd_mode}, e);
    endtask

    task automatic pulse_wake();
        @(posedge pclk);
        stop2_wake <= 1'b1;
        @(posedge pclk);
        stop2_wake <= 1'b0;
    endtask

    // ********************************************************
    // Test sequence
    // ********************************************************
    initial begin
        rst(pmsc_pkg::PMSC_CAUSE_POR);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h00, "ctrl2_por");
        wr(pmsc_pkg::ADDR_CTRL2, 32'h77);
        outc(32'hf);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h33, "ctrl2_rb");
        wr(pmsc_pkg::ADDR_CTRL2, 32'h00);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h03, "ctrl2_once");
        @(posedge pclk) warning_present <= 1'b1;
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h83, "warn_set");
        @(negedge pclk);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(pmsc_pkg::ADDR_CTRL2, 32'h40);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h83, "warn_ack_held");
        @(posedge pclk) warning_present <= 1'b0;
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h83, "warn_sticky");
        rdc(pmsc_pkg::ADDR_STATUS, 32'h1, "status");
        wr(pmsc_pkg::ADDR_MASK, 32'h3);
        repeat (2) @(negedge pclk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        rdc(pmsc_pkg::ADDR_IRQ, 32'h1 << pmsc_pkg::IRQ_WARN, "irq_warn");
        repeat (2) @(negedge pclk);
        chk("irq_off", {31'h0, irq}, 32'h0);
        wr(pmsc_pkg::ADDR_CTRL2, 32'h40);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h03, "warn_ack");
        pulse_wake();
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h0b, "s2_set");
        rdc(pmsc_pkg::ADDR_IRQ, 32'h1 << pmsc_pkg::IRQ_S2, "irq_s2");
        wr(pmsc_pkg::ADDR_CTRL2, 32'h00);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h0b, "s2_ack0");
        wr(pmsc_pkg::ADDR_CTRL2, 32'h04);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h03, "s2_ack1");
        wr(8'h10, 32'hff);
        chk("unmapped_err", {31'h0, rerr}, 32'h1);
        rdc(8'h10, 32'h0, "unmapped_rd");
        chk("unmapped_rd_err", {31'h0, rerr}, 32'h1);
        wr(pmsc_pkg::ADDR_CTRL2, 32'h30);
        pulse_wake();
        warning_present <= 1'b1;
        rst(pmsc_pkg::PMSC_CAUSE_LVR);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'hb0, "lvr_reset");
        warning_present <= 1'b0;
        rst(pmsc_pkg::PMSC_CAUSE_OTHER);
        rdc(pmsc_pkg::ADDR_CTRL2, 32'h30, "other_reset");
        rst(pmsc_pkg::PMSC_CAUSE_POR);
        wr(pmsc_pkg::ADDR_CTRL2, 32'h01);
        wr(pmsc_pkg::ADDR_CTRL2, 32'h03);
        outc(32'h1);
        print_verdict();
    end

    // Whole run is about 150 cycles; this leaves a wide margin
    initial begin
        #250000;
        error_cnt++;
        print_verdict();
    end
endmodule
